// >>> rtl/usb_cfg_pkg.sv
// Behaviour
// R1 - In high, full and low speed the two-bit scale-down code selects off, all but suspend/resume, suspend/resume only, or both.
// R2 - In SuperSpeed code one cuts equalisation training to 8 sequences, the polling burst to 100 ns and warm-reset detection to 30 us.
// R3 - In SuperSpeed code two suppresses all equalisation training and overrides the related bit 4 setting.
// R4 - Software should keep the scale-down field at zero on real hardware; it resets to zero.
// R5 - Field defaults come from the EEPROM image when present, else from OTP, else from a fixed fallback.
// R6 - A USB bus reset or lite reset restores each such field to the last loaded image value or its fallback.
// R7 - After a soft reset in SuperSpeed the device stays detached for the upper half-word in ms, fallback 30 ms.
// R8 - After a soft reset in high or full speed the device stays detached for the lower half-word in ms, fallback 10 ms.
// R9 - Both detach-time fields are kept across a protected reset.
// R10 - Once the burst limit of contiguous data has been sent the transmitter ends the burst with a zero-length packet.
// R11 - The eight-bit burst limit counts 1024, 512 or 64 byte units in super, high and full speed and resets to zero.
// R12 - The burst limit is ignored whenever it comes to at most 2048 bytes.
// R13 - The burst limit acts only when its enable bit in the first configuration register is set.
// R14 - Software must set the burst limit no smaller than the MAC maximum frame size.
// R15 - Before any short or zero-length packet the transmitter waits the bulk-in delay interval.
// R16 - The bulk-in delay counts in 16.667 ns steps and resets to 0800h, about 34.133 us.
// R17 - Reserved bits read as zero and ignore writes.
package usb_cfg_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_DETACH = 8'h88;
	localparam logic [7:0] ADDR_BURST = 8'h90;
	localparam logic [7:0] ADDR_DELAY = 8'h94;
	localparam logic [7:0] ADDR_SCALE = 8'h8C;
	localparam logic [7:0] ADDR_STATUS = 8'h98;
	// ----------------------------------------
	// fallback values and fields
	// ----------------------------------------
	localparam logic [15:0] SS_DETACH_FALLBACK = 16'h001E;
	localparam logic [15:0] HIGHSPEED_DETACH_MS_FALLBACK = 16'h000A;
	localparam logic [7:0] BURST_RESET = 8'h00;
	localparam logic [15:0] DELAY_RESET = 16'h0800;
	localparam logic [1:0] SCALE_RESET = 2'h0;
	localparam int SCALE_BIT_MAIN = 0;
	localparam int SCALE_BIT_SUSP = 1;
	localparam logic [1:0] SCALE_NO_TRAIN = 2'h2;
	// ----------------------------------------
	// burst units as byte shifts, threshold
	// ----------------------------------------
	localparam logic [3:0] SHIFT_SS = 4'hA;
	localparam logic [3:0] SHIFT_HS = 4'h9;
	localparam logic [3:0] SHIFT_FS = 4'h6;
	localparam logic [18:0] BURST_MIN_BYTES = 19'h00800;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int DELAY_STEP_PS = 16667;
	localparam int CLK_PERIOD_PS = 25000;
	localparam int TRAIN_SEQ_SCALED = 8;
	localparam int POLL_BURST_SCALED_NS = 100;
	localparam int WARM_RESET_SCALED_US = 30;
	typedef enum logic [1:0] {SPEED_FS, SPEED_HS, SPEED_SS} speed_e;
endpackage : usb_cfg_pkg

// >>> rtl/detach_timer.sv
`timescale 1ns/1ps
module detach_timer
	import usb_cfg_pkg::*;
#(
	parameter int MS_COUNT = MS_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [15:0] durationMs,
	output logic detached
);
	typedef struct packed {
		logic active;
		logic [15:0] msLeft;
		logic [31:0] tick;
	} st_s;
	st_s st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		if (start) begin
			st_next.active = (durationMs != 16'h0000);
			st_next.msLeft = durationMs;
			st_next.tick = 32'h0;
		end else if (st_reg.active) begin
			if (st_reg.tick == 32'(MS_COUNT - 1)) begin
				st_next.tick = 32'h0;
				st_next.msLeft = st_reg.msLeft - 16'h0001;
				if (st_reg.msLeft == 16'h0001) begin
					st_next.active = 1'b0;
				end
			end else begin
				st_next.tick = st_reg.tick + 32'h1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign detached = st_reg.active;
endmodule : detach_timer

// >>> rtl/short_delay_timer.sv
`timescale 1ns/1ps
module short_delay_timer
	import usb_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic request,
	input wire logic [15:0] steps,
	output logic grant
);
	// phase accumulator in ps: one step is 16.667 ns, not a whole number of clocks
	typedef struct packed {
		logic busy;
		logic done;
		logic [31:0] elapsed;
		logic [31:0] target;
	} st_s;
	st_s st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (!st_reg.busy && request && !st_reg.done) begin
			st_next.busy = 1'b1;
			st_next.elapsed = 32'h0;
			st_next.target = 32'(steps) * 32'(DELAY_STEP_PS);
		end else if (st_reg.busy) begin
			if (st_reg.elapsed >= st_reg.target) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end else begin
				st_next.elapsed = st_reg.elapsed + 32'(CLK_PERIOD_PS);
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign grant = st_reg.done;
endmodule : short_delay_timer

// >>> rtl/usb_bulkin_detach_config.sv
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module usb_bulkin_detach_config
	import usb_cfg_pkg::*;
#(
	parameter int MS_COUNT = MS_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// configuration image sources
	input wire logic eepromPresent,
	input wire logic otpConfigured,
	input wire logic imageLoad,
	input wire logic [15:0] eepromSsDetach,
	input wire logic [15:0] eepromHsDetach,
	input wire logic [15:0] otpSsDetach,
	input wire logic [15:0] otpHsDetach,
	// resets and link state
	input wire logic usbBusReset,
	input wire logic liteReset,
	input wire logic protectedReset,
	input wire logic softResetReq,
	input wire logic [1:0] linkSpeed,
	input wire logic burstLimitEnable,
	// bulk-in transmitter hooks
	input wire logic txBeat,
	input wire logic [10:0] txBeatBytes,
	input wire logic txShortPending,
	output logic txSendZlp,
	output logic txShortGo,
	output logic detached,
	// scale-down controls
	output logic scaleMainTimings,
	output logic scaleSuspendResume,
	output logic ssScaleTiming,
	output logic ssNoTraining,
	output logic [7:0] trainSeqLimit
);
	import usb_cfg_pkg::*;
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] ssDetach;
		logic [15:0] hsDetach;
		logic [15:0] imgSs;
		logic [15:0] imgHs;
		logic [7:0] burstLimit;
		logic [15:0] shortDelay;
		logic [1:0] scaleMode;
		logic [18:0] burstBytes;
		logic zlp;
		logic ack;
		logic [31:0] rdata;
	} st_s;
	st_s st_reg, st_next;
	logic [1:0] speedSync1_reg, speedSync2_reg;
	logic busReq;
	logic wrHit;
	logic [31:0] wmask;
	logic [31:0] wword;
	logic [31:0] rword;
	logic [15:0] srcSs;
	logic [15:0] srcHs;
	logic [18:0] limitBytes;
	logic limitActive;
	logic [15:0] detachSel;
	// ----------------------------------------
	// link speed from the PHY domain
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			speedSync1_reg <= 2'h0;
			speedSync2_reg <= 2'h0;
		end else begin
			speedSync1_reg <= linkSpeed;
			speedSync2_reg <= speedSync1_reg;
		end
	end
	// ----------------------------------------
	// derived values
	// ----------------------------------------
	always_comb begin
		if (eepromPresent) begin // [R5]
			srcSs = eepromSsDetach;
			srcHs = eepromHsDetach;
		end else if (otpConfigured) begin
			srcSs = otpSsDetach;
			srcHs = otpHsDetach;
		end else begin
			srcSs = SS_DETACH_FALLBACK;
			srcHs = HIGHSPEED_DETACH_MS_FALLBACK;
		end
	end
	always_comb begin
		case (speedSync2_reg) // [R11]
			SPEED_SS: limitBytes = 19'(st_reg.burstLimit) << SHIFT_SS;
			SPEED_HS: limitBytes = 19'(st_reg.burstLimit) << SHIFT_HS;
			default: limitBytes = 19'(st_reg.burstLimit) << SHIFT_FS;
		endcase
	end
	assign limitActive = burstLimitEnable && (limitBytes > BURST_MIN_BYTES); // [R12] [R13]
	assign busReq = wb_cyc_i && wb_stb_i && !st_reg.ack;
	assign wrHit = busReq && wb_we_i;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : laneMask
			assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
		end
	endgenerate
	always_comb begin
		rword = 32'h0; // [R17]
		case (wb_adr_i)
			ADDR_DETACH: rword = {st_reg.ssDetach, st_reg.hsDetach};
			ADDR_BURST: rword = {24'h0, st_reg.burstLimit};
			ADDR_DELAY: rword = {16'h0, st_reg.shortDelay};
			ADDR_SCALE: rword = {30'h0, st_reg.scaleMode};
			ADDR_STATUS: rword = {12'h0, limitActive, detached, speedSync2_reg, st_reg.burstBytes[15:0]};
			default: rword = 32'h0;
		endcase
		wword = (rword & ~wmask) | (wb_dat_i & wmask);
	end
	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.ack = busReq;
		st_next.zlp = 1'b0;
		if (busReq && !wb_we_i) begin
			st_next.rdata = rword;
		end
		if (imageLoad) begin
			st_next.imgSs = srcSs;
			st_next.imgHs = srcHs;
		end
		if (wrHit) begin
			case (wb_adr_i)
				ADDR_DETACH: begin
					st_next.ssDetach = wword[31:16];
					st_next.hsDetach = wword[15:0];
				end
				ADDR_BURST: st_next.burstLimit = wword[7:0];
				ADDR_DELAY: st_next.shortDelay = wword[15:0];
				ADDR_SCALE: st_next.scaleMode = wword[1:0];
				default: ;
			endcase
		end
		// protected reset leaves detach times alone
		if ((usbBusReset || liteReset) && !protectedReset) begin // [R6] [R9]
			st_next.ssDetach = st_reg.imgSs;
			st_next.hsDetach = st_reg.imgHs;
		end
		// contiguous byte count; short packet ends a burst naturally
		if (txShortPending) begin
			st_next.burstBytes = 19'h0;
		end else if (txBeat && limitActive) begin
			if (st_reg.burstBytes + 19'(txBeatBytes) >= limitBytes) begin // [R10]
				st_next.burstBytes = 19'h0;
				st_next.zlp = 1'b1;
			end else begin
				st_next.burstBytes = st_reg.burstBytes + 19'(txBeatBytes);
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.ssDetach <= SS_DETACH_FALLBACK;
			st_reg.hsDetach <= HIGHSPEED_DETACH_MS_FALLBACK;
			st_reg.imgSs <= SS_DETACH_FALLBACK;
			st_reg.imgHs <= HIGHSPEED_DETACH_MS_FALLBACK;
			st_reg.burstLimit <= BURST_RESET; // [R11]
			st_reg.shortDelay <= DELAY_RESET; // [R16]
			st_reg.scaleMode <= SCALE_RESET; // [R4]
		end else begin
			st_reg <= st_next;
		end
	end
	// ----------------------------------------
	// detach and short-packet delay
	// ----------------------------------------
	assign detachSel = (speedSync2_reg == SPEED_SS) ? st_reg.ssDetach : st_reg.hsDetach; // [R7] [R8]
	detach_timer #(
		.MS_COUNT(MS_COUNT)
	) detachTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(softResetReq),
		.durationMs(detachSel),
		.detached(detached)
	);
	// zlp after a capped burst also waits out the delay
	short_delay_timer shortDelay (
		.sys_clk(sys_clk),
		.rst(rst),
		.request(txShortPending || st_reg.zlp), // [R15]
		.steps(st_reg.shortDelay),
		.grant(txShortGo)
	);
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.rdata;
	assign txSendZlp = st_reg.zlp;
	assign scaleMainTimings = st_reg.scaleMode[SCALE_BIT_MAIN]; // [R1]
	assign scaleSuspendResume = st_reg.scaleMode[SCALE_BIT_SUSP];
	assign ssScaleTiming = (speedSync2_reg == SPEED_SS) && st_reg.scaleMode[SCALE_BIT_MAIN]; // [R2]
	// code three enables both scalings, so it drops training as well
	assign ssNoTraining = (speedSync2_reg == SPEED_SS)
		&& ((st_reg.scaleMode & SCALE_NO_TRAIN) != 2'h0); // [R3]
	assign trainSeqLimit = ssScaleTiming ? 8'(TRAIN_SEQ_SCALED) : 8'h0;
endmodule : usb_bulkin_detach_config

// >>> tb/cfg_checker_sva.sv
`timescale 1ns/1ps
module cfg_checker #(
	parameter int MS_COUNT = 10
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic softResetReq,
	input wire logic detached,
	input wire logic burstLimitEnable,
	input wire logic txSendZlp,
	input wire logic txShortPending,
	input wire logic txShortGo,
	input wire logic ssScaleTiming,
	input wire logic scaleMainTimings,
	input wire logic scaleSuspendResume,
	input wire logic ssNoTraining,
	input wire logic [7:0] trainSeqLimit
);
	int detLen;
	logic shortAsked;
	always_ff @(posedge sys_clk) begin
		detLen <= (rst || !detached) ? 0 : detLen + 1;
	end
	// a capped burst asks for the delay too, not only a pending short packet
	always_ff @(posedge sys_clk) begin
		if (rst || txShortGo) begin
			shortAsked <= 1'b0;
		end else if (txShortPending || txSendZlp) begin
			shortAsked <= 1'b1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence busReq;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence shortStart;
		$rose(txShortPending);
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_ack_follows_req: assert property (busReq |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_detach_starts: assert property (softResetReq && !detached |=> detached)
		else $error("detach did not start");
	a_detach_length: assert property ($fell(detached) |-> detLen >= MS_COUNT)
		else $error("detach shorter than one ms");
	a_zlp_needs_enable: assert property (txSendZlp |-> $past(burstLimitEnable))
		else $error("zlp while limit disabled");
	a_go_needs_pending: assert property (txShortGo |-> shortAsked)
		else $error("short go without request");
	a_ss_scale_main: assert property (ssScaleTiming |-> scaleMainTimings)
		else $error("ss scaling without code bit 0");
	a_ss_no_train: assert property (ssNoTraining |-> scaleSuspendResume)
		else $error("training suppressed without code bit 1");
	a_go_not_early: assert property (shortStart |=> !txShortGo [*8])
		else $error("short go too early");
	a_train_limit: assert property (trainSeqLimit == (ssScaleTiming ? 8'h08 : 8'h00))
		else $error("training limit wrong");
endmodule : cfg_checker

bind usb_bulkin_detach_config cfg_checker #(.MS_COUNT(MS_COUNT)) cfg_checker_inst (
	.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .softResetReq(softResetReq), .detached(detached),
	.burstLimitEnable(burstLimitEnable), .txSendZlp(txSendZlp),
	.txShortPending(txShortPending), .txShortGo(txShortGo),
	.ssScaleTiming(ssScaleTiming), .scaleMainTimings(scaleMainTimings),
	.scaleSuspendResume(scaleSuspendResume), .ssNoTraining(ssNoTraining),
	.trainSeqLimit(trainSeqLimit));

// >>> tb/bulkin_feeder.sv
`timescale 1ns/1ps
module bulkin_feeder (
	input wire logic sys_clk,
	input wire logic txShortGo,
	output logic txBeat,
	output logic [10:0] txBeatBytes,
	output logic txShortPending
);
	initial begin
		txBeat = 1'b0;
		txBeatBytes = 11'h7FF;
		txShortPending = 1'b0;
	end
	// beat sizes stay at most one unit, so a legal limit is never undercut
	task automatic send_beats(input int n, input logic [10:0] size);
		repeat (n) begin
			@(posedge sys_clk);
			txBeat <= 1'b1;
			txBeatBytes <= size;
			@(posedge sys_clk);
			txBeat <= 1'b0;
			txBeatBytes <= ~size;
		end
	endtask : send_beats
	task automatic short_packet(output int waited);
		waited = 0;
		@(posedge sys_clk);
		txShortPending <= 1'b1;
		do begin
			@(posedge sys_clk);
			waited++;
		end while (txShortGo !== 1'b1 && waited < 5000);
		txShortPending <= 1'b0;
	endtask : short_packet
endmodule : bulkin_feeder

// >>> tb/usb_bulkin_detach_config_tb.sv
`timescale 1ns/1ps
module usb_bulkin_detach_config_tb;
	import usb_cfg_pkg::*;
	localparam int MSC = 10;
	logic sys_clk, rst, wbCyc, wbStb, wbWe, wbAck, eepPres, otpCfg, imgLoad;
	logic busRst, liteRst, protRst, softReq, burstEn, txBeat, shortPend, zlp, shortGo;
	logic detached, sMain, sSusp, ssScale, ssNoTrain;
	logic [1:0] speed;
	logic [3:0] wbSel;
	logic [7:0] wbAdr, trainLim;
	logic [10:0] txBytes;
	logic [15:0] eSs, eHs, oSs, oHs;
	logic [31:0] wbDatI, wbDatO, rd;
	int badCount, checksDone, zlpSeen, w;
	logic [1:0] sp[5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h2};
	int lim[5] = '{3, 2, 5, 33, 3};
	int nb[5] = '{3, 4, 5, 33, 4};
	logic [10:0] sz[5] = '{11'h400, 11'h400, 11'h200, 11'h040, 11'h400};
	usb_bulkin_detach_config #(.MS_COUNT(MSC)) usb_bulkin_detach_config_inst (
		.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .eepromPresent(eepPres), .otpConfigured(otpCfg),
		.imageLoad(imgLoad), .eepromSsDetach(eSs), .eepromHsDetach(eHs),
		.otpSsDetach(oSs), .otpHsDetach(oHs), .usbBusReset(busRst), .liteReset(liteRst),
		.protectedReset(protRst), .softResetReq(softReq), .linkSpeed(speed),
		.burstLimitEnable(burstEn), .txBeat(txBeat), .txBeatBytes(txBytes),
		.txShortPending(shortPend), .txSendZlp(zlp), .txShortGo(shortGo),
		.detached(detached), .scaleMainTimings(sMain), .scaleSuspendResume(sSusp),
		.ssScaleTiming(ssScale), .ssNoTraining(ssNoTrain), .trainSeqLimit(trainLim));
	bulkin_feeder bulkin_feeder_inst (.sys_clk(sys_clk), .txShortGo(shortGo),
		.txBeat(txBeat), .txBeatBytes(txBytes), .txShortPending(shortPend));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (zlp === 1'b1) zlpSeen++;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wrapUp;
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrapUp
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check32
	task automatic check_range(input int got, input int lo, input int hi);
		checksDone++;
		if (got < lo || got > hi) begin
			badCount++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : check_range
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, adr, 4'hF, wd};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		rd = wbDatO;
		{wbCyc, wbStb} <= 2'b00;
		if (n >= 50) begin
			badCount++;
			wrapUp();
		end
	endtask : wb
	// 0 image load, 1 bus reset, 2 lite reset, 3 soft reset request
	task automatic pulse(input int sel);
		@(posedge sys_clk);
		case (sel)
			0: imgLoad <= 1'b1;
			1: busRst <= 1'b1;
			2: liteRst <= 1'b1;
			default: softReq <= 1'b1;
		endcase
		@(posedge sys_clk);
		{imgLoad, busRst, liteRst, softReq} <= 4'h0;
	endtask : pulse
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = {1'b1, 47'h0};
		{eepPres, otpCfg, imgLoad, busRst, liteRst, protRst, softReq, burstEn} = 8'h00;
		{eSs, eHs, oSs, oHs, speed} = {64'h0031_0013_0042_0024, 2'h0};
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wb(1'b0, 8'h88, 32'h0); check32(rd, 32'h001E000A);
		wb(1'b0, 8'h90, 32'h0); check32(rd, 32'h00000000);
		wb(1'b0, 8'h94, 32'h0); check32(rd, 32'h00000800);
		wb(1'b0, 8'h8C, 32'h0); check32(rd, 32'h00000000);
		wb(1'b1, 8'hA0, 32'hFFFFFFFF); wb(1'b0, 8'hA0, 32'h0); check32(rd, 32'h0);
		wb(1'b1, 8'h90, 32'hFFFFFFFF); wb(1'b0, 8'h90, 32'h0); check32(rd, 32'hFF);
		wb(1'b1, 8'h94, 32'hFFFF001E); wb(1'b0, 8'h94, 32'h0); check32(rd, 32'h1E);
		for (int c = 0; c < 4; c++) begin
			wb(1'b1, 8'h8C, 32'(c)); wb(1'b0, 8'h8C, 32'h0); check32(rd, 32'(c));
			speed <= 2'h0;
			repeat (4) @(posedge sys_clk);
			check32({sSusp, sMain}, 32'(c));
			speed <= 2'h2;
			repeat (4) @(posedge sys_clk);
			check32({ssNoTrain, ssScale}, 32'(c));
			check32(trainLim, c[0] ? 32'h8 : 32'h0);
		end
		wb(1'b1, 8'h8C, 32'h0);
		for (int k = 0; k < 3; k++) begin
			{eepPres, otpCfg} <= (k == 0) ? 2'b11 : (k == 1) ? 2'b01 : 2'b00;
			pulse(0);
			wb(1'b1, 8'h88, 32'h12345678);
			pulse((k == 0) ? 1 : 2);
			wb(1'b0, 8'h88, 32'h0);
			check32(rd, (k == 0) ? 32'h00310013 : (k == 1) ? 32'h00420024 : 32'h001E000A);
		end
		protRst <= 1'b1;
		wb(1'b1, 8'h88, 32'h00020001);
		pulse(2);
		wb(1'b0, 8'h88, 32'h0); check32(rd, 32'h00020001);
		protRst <= 1'b0;
		for (int s = 0; s < 2; s++) begin
			speed <= s ? 2'h2 : 2'h0;
			repeat (4) @(posedge sys_clk);
			pulse(3);
			// detached is launched by the edge that samples the request
			@(posedge sys_clk);
			w = 0;
			while (detached === 1'b1 && w < 1000) begin
				@(posedge sys_clk);
				w++;
			end
			check_range(w, (s + 1) * MSC - 2, (s + 1) * MSC + 2);
		end
		bulkin_feeder_inst.short_packet(w); check_range(w, 21, 26);
		for (int b = 0; b < 5; b++) begin
			speed <= sp[b];
			burstEn <= (b != 4);
			wb(1'b1, 8'h90, 32'(lim[b]));
			bulkin_feeder_inst.short_packet(w); check_range(w, 1, 4999);
			zlpSeen = 0;
			bulkin_feeder_inst.send_beats(nb[b], sz[b]);
			repeat (4) @(posedge sys_clk);
			check32(32'(zlpSeen), (b == 1 || b == 4) ? 32'h0 : 32'h1);
		end
		wb(1'b0, 8'h98, 32'h0); check32(rd, 32'h00020000);
		wrapUp();
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		badCount++;
		wrapUp();
	end
endmodule : usb_bulkin_detach_config_tb
